// ---- shared/slsoc_pkg.sv ----
package slsoc_pkg;
    // Frame and register geometry
    localparam int          SLSOC_WORD_BITS   = 8;
    localparam logic [7:0]  SLSOC_CTRL_RESET  = 8'h00;
    localparam logic [3:0]  SLSOC_BIT_CNT_W0  = 4'h0;
    localparam logic [3:0]  SLSOC_BIT_CNT_ONE = 4'h1;
    localparam logic [3:0]  SLSOC_BIT_CNT_MAX = 4'hF;
    localparam logic [3:0]  SLSOC_BIT_CNT_FULL = 4'h8;
    localparam logic [2:0]  SLSOC_MSB_IDX     = 3'h7;
    localparam int          SLSOC_CH1_IDX     = 0;

    // System clock
    localparam int          SLSOC_CLK_PS      = 4000;

    // Link timing in ns, as printed
    localparam int          SLSOC_T_CS_TO_RISE_NS = 10;
    localparam int          SLSOC_T_CS_TO_FALL_NS = 80;
    localparam int          SLSOC_T_SCLK_HALF_NS  = 60;
    localparam int          SLSOC_T_FALL_TO_CS_NS = 80;
    localparam int          SLSOC_T_WORD_GAP_NS   = 170;

    // Least times, rounded up to whole cycles
    localparam int SLSOC_CYC_CS_TO_RISE = (SLSOC_T_CS_TO_RISE_NS * 1000 + SLSOC_CLK_PS - 1) / SLSOC_CLK_PS;
    localparam int SLSOC_CYC_CS_TO_FALL = (SLSOC_T_CS_TO_FALL_NS * 1000 + SLSOC_CLK_PS - 1) / SLSOC_CLK_PS;
    localparam int SLSOC_CYC_HALF       = (SLSOC_T_SCLK_HALF_NS * 1000 + SLSOC_CLK_PS - 1) / SLSOC_CLK_PS;
    localparam int SLSOC_CYC_FALL_TO_CS = (SLSOC_T_FALL_TO_CS_NS * 1000 + SLSOC_CLK_PS - 1) / SLSOC_CLK_PS;
    localparam int SLSOC_CYC_GAP        = (SLSOC_T_WORD_GAP_NS * 1000 + SLSOC_CLK_PS - 1) / SLSOC_CLK_PS;

    // Timer width for the master's phase counter
    localparam logic [5:0]  SLSOC_TMR_ZERO = 6'h00;
    localparam logic [5:0]  SLSOC_TMR_ONE  = 6'h01;

    // Master sequencer states
    typedef enum logic [2:0] {
        SLSOC_M_IDLE,
        SLSOC_M_SETUP,
        SLSOC_M_LOW,
        SLSOC_M_HIGH,
        SLSOC_M_TAIL,
        SLSOC_M_GAP
    } slsoc_mstate_t;
endpackage

// ---- shared/slsoc_if.sv ----
// Serial link between the bus master and the output controller
interface slsoc_if;
    logic chip_select_n;  // Frame select, active low
    logic sclk;           // Serial clock from the master
    logic mosi;           // Serial data, MSB first

    modport master (
        output chip_select_n,
        output sclk,
        output mosi
    );

    modport device (
        input chip_select_n,
        input sclk,
        input mosi
    );
endinterface

// ---- rtl/slsoc_device.sv ----
// Contract
// R01 - Register bit one turns channel on
// R02 - Master rewrites at twice PWM, max 5kHz
// R03 - Max rate: new byte every 100 us
// R04 - Force pin high holds channel 1 on
// R05 - One 8-bit word sets all channels
// R06 - Ignore clock and data while deselected
// R07 - Chip select rise latches byte atomically
// R08 - Master keeps clock low while deselected
// R09 - 10 ns select to first rise
// R10 - 80 ns select to first fall
// R11 - Clock high and low at least 60 ns
// R12 - 80 ns last fall to deselect
// R13 - At least 170 ns between words
// R14 - Most significant bit sent first
// R15 - Wrong bit count discards the frame
module slsoc_device
    import slsoc_pkg::*;
(
    input  wire logic       CLK_SYS,          // System clock
    input  wire logic       RST_N,            // Synchronous reset, active low
    slsoc_if.device         link,             // Serial link from the master
    input  wire logic       CHANNEL1_FORCE_ON_PIN, // Forces channel 1 on when high
    output logic [7:0]      CHANNEL_DRIVERS,  // Driver enables, bit 0 is channel 1
    output logic [7:0]      OUTPUT_CONTROL    // Current register contents
);
    // Overview
    // The block is a write-only serial port in front of an eight-bit control
    // register. Each register bit enables one low-side driver, bit 0 for
    // channel 1 up to bit 7 for channel 8. Nothing can be read back over the
    // link; the register contents are brought out on a port for the system.
    //
    // Clock domains
    // The link clock belongs to the master and is never used as a clock here.
    // Select, clock, data and the force pin all pass two flip-flops on the
    // system clock before any logic reads them. Edges of the link clock are
    // found by comparing the second stage with its previous value.
    // Because of this, the link clock must be well below a quarter of the
    // system clock. At 250 MHz and the 60 ns least phase there are about
    // fifteen samples per phase, so no edge is ever missed.
    //
    // Sampling
    // Data is taken on the rising link clock edge as seen after the
    // synchronisers. Data and clock travel through identical stages, so the
    // data bit seen beside the rise is the bit that stood at the pin when the
    // rise happened. The master changes data on the falling edge, which
    // leaves the full low phase before the rise and the full high phase after it as margin.
    //
    // Frame sequence
    // Select falls: the bit counter is already cleared from the idle time.
    // Each qualified rise shifts one bit in at the bottom, so the first bit
    // ends in the top position and the eighth in bit 0.
    // Select rises: if exactly eight rises were counted, the shifted byte
    // is copied into the register in one step; every bit moves at once.
    // The driver register follows one edge later, again all bits together.
    //
    // Discard cases
    // Fewer than eight rises: the count does not match, nothing is written.
    // More than eight rises: the counter keeps going and saturates, so a
    // very long frame can never wrap back to a count of eight.
    // Clock activity while deselected never reaches the shifter or the
    // counter, so a noisy idle line cannot corrupt the next frame.
    //
    // Force pin
    // The force pin is ORed into channel 1 after its own two-stage sync.
    // It does not change the register, so once the pin drops channel 1
    // returns to whatever its register bit says.
    // An open pin is expected to be pulled low outside the block.
    //
    // Reset
    // Reset is synchronous and active low. The select synchroniser resets
    // to the deselected level and the edge history matches it, so leaving
    // reset never creates a false select rise or a false clock rise.
    // Register and drivers come out of reset with all channels off.
    //
    // Latency
    // From the select rise at the pin: two sync stages, one edge for the
    // rise detect and the register update, then one more for the drivers.
    // A master that rewrites the register for pulse-width control only sees
    // this as a fixed offset of a few system clocks on every update.
    //
    // Limitations
    // The link timing itself is not checked here; a master that breaks the
    // least phase or gap times may lose bits without any indication.
    // There is no error flag for a discarded frame by design: the port is
    // write-only, so the master would have no way to read such a flag.
    // A frame that is cut by reset is simply lost; the register goes to
    // its reset value and the next complete frame sets it again.
    //
    // Trade-offs
    // The synchronisers cost a few cycles of latency on each update, but
    // keep the whole block on one clock with no second clock domain.
    // Registering the drivers adds one more cycle but gives clean outputs
    // that come straight from flip-flops, with no glitch from the force OR.
    // Two-stage synchronisers for the link pins and the force pin
    logic [3:0] sync1_ff;       // First stage, read only by second stage
    logic [3:0] sync2_ff;       // Second stage
    logic [3:0] nxt_sync1;
    logic [3:0] nxt_sync2;
    logic       sclk_prev_ff;   // Previous synced clock for edge finding
    logic       cs_prev_ff;     // Previous synced select
    logic       nxt_sclk_prev;
    logic       nxt_cs_prev;

    // Shifter, bit counter and output register
    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic [3:0] bit_cnt_ff;     // Saturates so overlong frames stay wrong
    logic [3:0] nxt_bit_cnt;
    logic [7:0] ctrl_ff;        // Output control register
    logic [7:0] nxt_ctrl;
    logic [7:0] drv_ff;         // Registered driver enables
    logic [7:0] nxt_drv;

    // Synced views
    logic cs_n_s;
    logic sclk_s;
    logic mosi_s;
    logic force_s;
    logic sclk_rise;
    logic cs_rise;

    assign cs_n_s  = sync2_ff[0];
    assign sclk_s  = sync2_ff[1];
    assign mosi_s  = sync2_ff[2];
    assign force_s = sync2_ff[3];

    // Synchroniser next values
    always_comb begin
        nxt_sync1     = {CHANNEL1_FORCE_ON_PIN, link.mosi, link.sclk, link.chip_select_n};
        nxt_sync2     = sync1_ff;
        nxt_sclk_prev = sclk_s;
        nxt_cs_prev   = cs_n_s;
    end

    // Synchroniser registers; select resets high so no false edge appears
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sync1_ff     <= 4'h1;
            sync2_ff     <= 4'h1;
            sclk_prev_ff <= 1'b0;
            cs_prev_ff   <= 1'b1;
        end else begin
            sync1_ff     <= nxt_sync1;
            sync2_ff     <= nxt_sync2;
            sclk_prev_ff <= nxt_sclk_prev;
            cs_prev_ff   <= nxt_cs_prev;
        end
    end

    // Edges seen on the synced copies only
    assign sclk_rise = sclk_s & ~sclk_prev_ff & ~cs_n_s; // R06
    assign cs_rise   = cs_n_s & ~cs_prev_ff;

    // Frame logic: shift, count, latch or discard
    always_comb begin
        nxt_shift   = shift_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_ctrl    = ctrl_ff;
        if (cs_n_s) begin
            // Deselected: clock and data ignored, counter rearmed
            nxt_bit_cnt = SLSOC_BIT_CNT_W0; // R06
            if (cs_rise && bit_cnt_ff == SLSOC_BIT_CNT_FULL) begin
                nxt_ctrl = shift_ff; // R07 R05
            end
            // Any other count leaves the register untouched
        end else if (sclk_rise) begin
            // Sample on rising edge, first bit lands in the MSB
            nxt_shift = {shift_ff[6:0], mosi_s}; // R14
            if (bit_cnt_ff != SLSOC_BIT_CNT_MAX) begin
                nxt_bit_cnt = bit_cnt_ff + SLSOC_BIT_CNT_ONE; // R15
            end
        end
    end

    // Driver enables: register bit, channel 1 also forced by pin
    always_comb begin
        nxt_drv = ctrl_ff; // R01
        nxt_drv[SLSOC_CH1_IDX] = ctrl_ff[SLSOC_CH1_IDX] | force_s; // R04
    end

    // Frame and output registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            shift_ff   <= SLSOC_CTRL_RESET;
            bit_cnt_ff <= SLSOC_BIT_CNT_W0;
            ctrl_ff    <= SLSOC_CTRL_RESET;
            drv_ff     <= SLSOC_CTRL_RESET;
        end else begin
            shift_ff   <= nxt_shift;
            bit_cnt_ff <= nxt_bit_cnt;
            ctrl_ff    <= nxt_ctrl;
            drv_ff     <= nxt_drv;
        end
    end

    // All eight drivers update on the same edge
    assign CHANNEL_DRIVERS = drv_ff; // R07
    assign OUTPUT_CONTROL  = ctrl_ff;
endmodule

// ---- rtl/slsoc_master.sv ----
// Bus master end: sends one byte per request with all link timing met
module slsoc_master
    import slsoc_pkg::*;
(
    input  wire logic       CLK_SYS,   // System clock
    input  wire logic       RST_N,     // Synchronous reset, active low
    slsoc_if.master         link,      // Serial link to the device
    input  wire logic       SEND_REQ,  // Request pulse or level, taken when READY
    input  wire logic [7:0] SEND_DATA, // Byte to send
    output logic            READY      // High when a request can be taken
);
    slsoc_mstate_t state_ff;
    slsoc_mstate_t nxt_state;
    logic [5:0]    tmr_ff;      // Phase timer, counts down
    logic [5:0]    nxt_tmr;
    logic [7:0]    data_ff;     // Byte being shifted out
    logic [7:0]    nxt_data;
    logic [2:0]    bit_ff;      // Bits still to send minus one
    logic [2:0]    nxt_bit;
    logic          cs_n_ff;
    logic          nxt_cs_n;
    logic          sclk_ff;
    logic          nxt_sclk;
    logic          mosi_ff;
    logic          nxt_mosi;
    logic          ready_ff;
    logic          nxt_ready;

    // Sequencer: select lead, first high, seven low/high pairs, tail, inter-word gap
    always_comb begin
        nxt_state = state_ff;
        nxt_tmr   = tmr_ff;
        nxt_data  = data_ff;
        nxt_bit   = bit_ff;
        nxt_cs_n  = cs_n_ff;
        nxt_sclk  = sclk_ff;
        nxt_mosi  = mosi_ff;
        nxt_ready = 1'b0;
        if (tmr_ff != SLSOC_TMR_ZERO) begin
            nxt_tmr = tmr_ff - SLSOC_TMR_ONE;
        end
        case (state_ff)
            SLSOC_M_IDLE: begin
                nxt_sclk  = 1'b0; // R08
                nxt_ready = 1'b1;
                if (SEND_REQ && ready_ff) begin
                    nxt_ready = 1'b0;
                    nxt_data  = SEND_DATA;
                    nxt_mosi  = SEND_DATA[SLSOC_MSB_IDX]; // R14
                    nxt_bit   = SLSOC_MSB_IDX;
                    nxt_cs_n  = 1'b0;
                    // Longer of the first-rise lead and the first-fall lead minus one high phase
                    nxt_tmr   = 6'(SLSOC_CYC_CS_TO_RISE > SLSOC_CYC_CS_TO_FALL - SLSOC_CYC_HALF ?
                                   SLSOC_CYC_CS_TO_RISE : SLSOC_CYC_CS_TO_FALL - SLSOC_CYC_HALF); // R09 R10
                    nxt_state = SLSOC_M_SETUP;
                end
            end
            SLSOC_M_SETUP: begin
                if (tmr_ff == SLSOC_TMR_ONE) begin
                    nxt_sclk  = 1'b1;
                    nxt_tmr   = 6'(SLSOC_CYC_HALF); // R11
                    nxt_state = SLSOC_M_HIGH;
                end
            end
            SLSOC_M_HIGH: begin
                if (tmr_ff == SLSOC_TMR_ONE) begin
                    nxt_sclk  = 1'b0;
                    nxt_tmr   = 6'(SLSOC_CYC_HALF); // R11
                    if (bit_ff == 3'h0) begin
                        nxt_tmr   = 6'(SLSOC_CYC_FALL_TO_CS); // R12
                        nxt_state = SLSOC_M_TAIL;
                    end else begin
                        // Data changes on the falling edge, well clear of the rise
                        nxt_data  = {data_ff[6:0], 1'b0};
                        nxt_mosi  = data_ff[6]; // R14
                        nxt_bit   = bit_ff - 3'h1; // R05
                        nxt_state = SLSOC_M_LOW;
                    end
                end
            end
            SLSOC_M_LOW: begin
                if (tmr_ff == SLSOC_TMR_ONE) begin
                    nxt_sclk  = 1'b1;
                    nxt_tmr   = 6'(SLSOC_CYC_HALF);
                    nxt_state = SLSOC_M_HIGH;
                end
            end
            SLSOC_M_TAIL: begin
                if (tmr_ff == SLSOC_TMR_ONE) begin
                    nxt_cs_n  = 1'b1;
                    nxt_tmr   = 6'(SLSOC_CYC_GAP); // R13
                    nxt_state = SLSOC_M_GAP;
                end
            end
            SLSOC_M_GAP: begin
                if (tmr_ff == SLSOC_TMR_ONE) begin
                    nxt_ready = 1'b1;
                    nxt_state = SLSOC_M_IDLE;
                end
            end
            default: begin
                nxt_state = SLSOC_M_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            state_ff <= SLSOC_M_IDLE;
            tmr_ff   <= SLSOC_TMR_ZERO;
            data_ff  <= SLSOC_CTRL_RESET;
            bit_ff   <= 3'h0;
            cs_n_ff  <= 1'b1;
            sclk_ff  <= 1'b0;
            mosi_ff  <= 1'b0;
            ready_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tmr_ff   <= nxt_tmr;
            data_ff  <= nxt_data;
            bit_ff   <= nxt_bit;
            cs_n_ff  <= nxt_cs_n;
            sclk_ff  <= nxt_sclk;
            mosi_ff  <= nxt_mosi;
            ready_ff <= nxt_ready;
        end
    end

    assign link.chip_select_n = cs_n_ff;
    assign link.sclk          = sclk_ff;
    assign link.mosi          = mosi_ff;
    assign READY              = ready_ff;
endmodule

// ---- verif/slsoc_properties.sv ----
// Watches the link between the two design ends
module slsoc_properties (
    input  wire logic CLK_SYS,       // System clock
    input  wire logic RST_N,         // Synchronous reset, active low
    input  wire logic chip_select_n, // Frame select, active low
    input  wire logic sclk,          // Serial clock from the master
    input  wire logic mosi           // Serial data
);
    logic [5:0] sclk_cnt_ff;  // Samples the last clock level has held
    logic [5:0] cs_cnt_ff;    // Samples the last select level has held
    logic [3:0] rises_ff;     // Clock rises in this frame
    logic       sclk_q_ff;    // Clock one sample ago
    logic       cs_q_ff;      // Select one sample ago
    logic [5:0] nxt_sclk_cnt; // Next clock level count
    logic [5:0] nxt_cs_cnt;   // Next select level count
    logic [3:0] nxt_rises;    // Next rise count

    // Level counters saturate so a long idle never wraps into a false short phase
    always_comb begin
        nxt_sclk_cnt = (sclk != sclk_q_ff) ? 6'h01 : sclk_cnt_ff + {5'h00, sclk_cnt_ff != 6'h3F};
        nxt_cs_cnt = (chip_select_n != cs_q_ff) ? 6'h01 : cs_cnt_ff + {5'h00, cs_cnt_ff != 6'h3F};
        nxt_rises = chip_select_n ? 4'h0 : rises_ff + {3'h0, sclk & ~sclk_q_ff};
    end

    // Register the helpers; reset looks like a long idle
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sclk_cnt_ff <= 6'h3F;
            cs_cnt_ff   <= 6'h3F;
            rises_ff    <= 4'h0;
            sclk_q_ff   <= 1'b0;
            cs_q_ff     <= 1'b1;
        end else begin
            sclk_cnt_ff <= nxt_sclk_cnt;
            cs_cnt_ff   <= nxt_cs_cnt;
            rises_ff    <= nxt_rises;
            sclk_q_ff   <= sclk;
            cs_q_ff     <= chip_select_n;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    sclk_idle_low_a: assert property (chip_select_n |-> !sclk)
        else $error("serial clock high while deselected");
    lead_to_rise_a: assert property ($fell(chip_select_n) |-> !sclk [*3])
        else $error("first clock rise too soon after select");
    lead_to_fall_a: assert property ($fell(sclk) && rises_ff == 4'h1 |-> cs_cnt_ff >= 6'd20)
        else $error("first clock fall too soon after select");
    clock_phase_min_a: assert property ((sclk != sclk_q_ff) && (sclk_q_ff || rises_ff != 4'h0)
        |-> sclk_cnt_ff >= 6'd15)
        else $error("clock phase shorter than 60 ns");
    tail_before_deselect_a: assert property ($rose(chip_select_n) |-> sclk_cnt_ff >= 6'd20)
        else $error("deselect too soon after last fall");
    word_gap_a: assert property ($fell(chip_select_n) |-> cs_cnt_ff >= 6'd43)
        else $error("gap between words below 170 ns");
    eight_bit_frame_a: assert property ($rose(chip_select_n) |-> rises_ff == 4'h8)
        else $error("frame did not carry eight clocks");
    data_held_high_a: assert property (sclk |-> $stable(mosi))
        else $error("data moved while clock high");
endmodule

// ---- verif/slsoc_tb_top.sv ----
// Two devices: one fed by the master, one by a bench driver that breaks framing
module slsoc_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_sys;          // Bench clock, 250 MHz
    logic       rst_n;            // Reset, active low
    logic       send_req;         // Request to the master
    logic [7:0] send_data;        // Byte for the master
    logic       ready;            // Master can take a request
    logic       force_on;         // Channel 1 force pin of the first device
    logic [7:0] drv_a;            // Driver enables, first device
    logic [7:0] ctrl_a;           // Register, first device
    logic [7:0] ctrl_b;           // Register, driven device
    int         num_errors = 0;   // Mismatches
    int         cmp_count = 0;    // Comparisons
    int         cycles = 0;       // Clock cycles run
    slsoc_if    link_a ();        // Master to first device
    slsoc_if    link_b ();        // Bench driver to second device

    slsoc_master slsoc_master_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .link(link_a),
        .SEND_REQ(send_req), .SEND_DATA(send_data), .READY(ready));
    slsoc_device slsoc_device_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .link(link_a),
        .CHANNEL1_FORCE_ON_PIN(force_on), .CHANNEL_DRIVERS(drv_a), .OUTPUT_CONTROL(ctrl_a));
    // Second device: force pin tied low, only framing is under test here
    slsoc_device slsoc_device_inst_b (.CLK_SYS(clk_sys), .RST_N(rst_n), .link(link_b),
        .CHANNEL1_FORCE_ON_PIN(1'b0), .CHANNEL_DRIVERS(), .OUTPUT_CONTROL(ctrl_b));
    slsoc_properties slsoc_properties_inst (.CLK_SYS(clk_sys), .RST_N(rst_n),
        .chip_select_n(link_a.chip_select_n), .sclk(link_a.sclk), .mosi(link_a.mosi));

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Hang guard: whole run is well under this
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            conclude();
        end
    end

    // Advance n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Bounded wait for the master to go idle
    task automatic wait_ready();
        for (int i = 0; i < 400 && ready !== 1'b1; i++) tick(1);
        check({7'h00, ready}, 8'h01);
    endtask

    // One byte through the master; register must hold until deselect
    task automatic send(input logic [7:0] data, input logic [7:0] prev);
        wait_ready();
        send_req = 1'b1;
        send_data = data;
        tick(1);
        send_req = 1'b0;
        tick(100);
        check(ctrl_a, prev);
        wait_ready();
        check(ctrl_a, data);
        check(drv_a, {data[7:1], data[0] | force_on});
    endtask

    // Bench-made frame of n bits at a 32 ns link clock; cs_hi keeps it deselected
    task automatic raw(input logic [8:0] bits, input int n, input logic cs_hi);
        link_b.chip_select_n = cs_hi;
        tick(3);
        for (int i = n - 1; i >= 0; i--) begin
            link_b.mosi = bits[i];
            tick(4);
            link_b.sclk = 1'b1;
            tick(4);
            link_b.sclk = 1'b0;
        end
        tick(20);
        link_b.chip_select_n = 1'b1;
        link_b.mosi = ~link_b.mosi;  // Released line does not keep its value
        tick(45);
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        send_req = 1'b0;
        send_data = 8'h00;
        force_on = 1'b0;
        link_b.chip_select_n = 1'b1;
        link_b.sclk = 1'b0;
        link_b.mosi = 1'b0;
        tick(6);
        rst_n = 1'b1;
        tick(4);
        check(ctrl_a, 8'h00);
        check(drv_a, 8'h00);
        send(8'h01, 8'h00);
        send(8'h80, 8'h01);
        send(8'h6B, 8'h80);
        force_on = 1'b1;
        send(8'hFE, 8'h6B);
        send(8'h00, 8'hFE);
        force_on = 1'b0;
        tick(5);
        check(drv_a, 8'h00);
        send(8'hFF, 8'h00);
        raw(9'h0C3, 8, 1'b0);
        check(ctrl_b, 8'hC3);
        raw(9'h05A, 7, 1'b0);
        check(ctrl_b, 8'hC3);
        raw(9'h15A, 9, 1'b0);
        check(ctrl_b, 8'hC3);
        raw(9'h05A, 8, 1'b1);
        check(ctrl_b, 8'hC3);
        raw(9'h01D, 8, 1'b0);
        check(ctrl_b, 8'h1D);
        rst_n = 1'b0;
        tick(6);
        rst_n = 1'b1;
        tick(4);
        check(ctrl_a, 8'h00);
        check(ctrl_b, 8'h00);
        send(8'h5C, 8'h00);
        // Pulse-width style rewrite at the fastest allowed update interval
        tick(24700);
        send(8'h5D, 8'h5C);
        conclude();
    end
endmodule
